// [driver_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module driver_seq
   import drv_pwr_pkg::*;
#(
   parameter logic [DLY_W-1:0] RAMP_STEP = DLY_W'(RAMP_STEP_CYC)
) (
   input wire logic clk,
   input wire logic rst_b,
   drv_if.seq d
);
   typedef enum logic [2:0] {S_OFF, S_WAIT, S_RAMP, S_ON, S_SHUT} state_t;
   state_t state_q, state_d;
   logic [DLY_W-1:0] cnt_q, cnt_d;
   logic [ATTEN_W-1:0] atten_q, atten_d;
   logic trip;

   assign trip = d.shorted & d.auto_off;
   assign d.powered = (state_q == S_RAMP) || (state_q == S_ON);
   assign d.limiting = d.powered & d.shorted;
   assign d.short_flag = (state_q == S_SHUT) | d.limiting;
   assign d.atten = atten_q;

   // sequencing; dropping the request always wins
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      atten_d = atten_q;
      case (state_q)
         S_OFF: begin
            if (d.pwr_req) begin
               state_d = S_WAIT;
               cnt_d = d.delay_cyc;
            end
         end
         S_WAIT: begin
            if (!d.pwr_req) begin
               state_d = S_OFF;
            end else if (cnt_q == '0) begin
               if (d.ramp_en) begin
                  state_d = S_RAMP;
                  atten_d = ATTEN_START;
                  cnt_d = RAMP_STEP - CNT_ONE;
               end else begin
                  state_d = S_ON;
                  atten_d = '0;
               end
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         S_RAMP: begin
            if (!d.pwr_req) begin
               state_d = S_OFF;
            end else if (trip) begin
               state_d = S_SHUT;
            end else if (cnt_q == '0) begin
               atten_d = atten_q - 6'h01;
               cnt_d = RAMP_STEP - CNT_ONE;
               if (atten_q == 6'h01) begin
                  state_d = S_ON;
               end
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         S_ON: begin
            if (!d.pwr_req) begin
               state_d = S_OFF;
            end else if (trip) begin
               state_d = S_SHUT;
            end
         end
         S_SHUT: begin
            if (!d.pwr_req) begin
               state_d = S_OFF;
            end
         end
         default: state_d = S_OFF;
      endcase
   end

   // state registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_OFF;
         cnt_q <= '0;
         atten_q <= ATTEN_START;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         atten_q <= atten_d;
      end
   end

   property p_trip_off;
      @(posedge clk) disable iff (!rst_b)
      (state_q == S_ON && d.pwr_req && trip) |=> !d.powered && d.short_flag;
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("no auto off");

   property p_shut_hold;
      @(posedge clk) disable iff (!rst_b)
      (state_q == S_SHUT && d.pwr_req) |=> state_q == S_SHUT && d.short_flag;
   endproperty
   a_shut_hold: assert property (p_shut_hold) else $error("shut left");

   property p_clear;
      @(posedge clk) disable iff (!rst_b)
      (state_q == S_SHUT && !d.pwr_req) |=> !d.short_flag ##1 !d.powered;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_limit;
      @(posedge clk) disable iff (!rst_b)
      (state_q == S_ON && d.shorted && !d.auto_off && d.pwr_req)
         |-> d.limiting ##1 d.powered;
   endproperty
   a_limit: assert property (p_limit) else $error("limit lost power");

   property p_ramp_start;
      @(posedge clk) disable iff (!rst_b)
      (state_q == S_WAIT && d.pwr_req && cnt_q == '0 && d.ramp_en)
         |=> atten_q == ATTEN_START && d.powered;
   endproperty
   a_ramp_start: assert property (p_ramp_start) else $error("bad start");

   property p_ramp_step;
      @(posedge clk) disable iff (!rst_b)
      (state_q == S_RAMP && cnt_q == '0 && d.pwr_req && !trip)
         |=> atten_q == $past(atten_q) - 6'h01;
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("bad step");

   property p_instant;
      @(posedge clk) disable iff (!rst_b)
      (state_q == S_OFF && d.pwr_req && d.delay_cyc == '0 && !d.ramp_en)
         ##1 d.pwr_req |=> d.powered;
   endproperty
   a_instant: assert property (p_instant) else $error("delay not zero");
endmodule : driver_seq
`default_nettype wire

// [drv_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface drv_if;
   import drv_pwr_pkg::*;
   logic pwr_req;
   logic auto_off;
   logic ramp_en;
   logic shorted;
   logic [DLY_W-1:0] delay_cyc;
   logic powered;
   logic short_flag;
   logic limiting;
   logic [ATTEN_W-1:0] atten;
   modport ctl (output pwr_req, auto_off, ramp_en, shorted, delay_cyc,
      input powered, short_flag, limiting, atten);
   modport seq (input pwr_req, auto_off, ramp_en, shorted, delay_cyc,
      output powered, short_flag, limiting, atten);
endinterface : drv_if
`default_nettype wire

// [drv_pwr_pkg.sv]
package drv_pwr_pkg;
   // register offsets
   localparam logic [6:0] ADDR_HSDET = 7'h0D;
   localparam logic [6:0] ADDR_OUTCFG = 7'h0E;
   localparam logic [6:0] ADDR_RAMP = 7'h28;
   localparam logic [6:0] ADDR_PUDLY = 7'h2A;
   localparam logic [6:0] ADDR_SHORT = 7'h5F;
   // values after reset
   localparam logic [7:0] RST_HSDET = 8'h00;
   localparam logic [7:0] RST_OUTCFG = 8'h00;
   localparam logic [7:0] RST_RAMP = 8'h01;
   localparam logic [7:0] RST_PUDLY = 8'h00;
   // field positions
   localparam int OUTCFG_MODE_LSB = 0;
   localparam int OUTCFG_DIRECT_BIT = 3;
   localparam int OUTCFG_PWR_LSB = 4;
   localparam int RAMP_EN_BIT = 0;
   localparam int RAMP_AUTO_OFF_BIT = 1;
   localparam int PUDLY_IDLE_LSB = 2;
   localparam int PUDLY_CODE_LSB = 4;
   localparam int HSDET_AC_BIT = 4;
   localparam int HSDET_TYPE_LSB = 5;
   localparam int HSDET_EN_BIT = 7;
   // sizes
   localparam int DRV_N = 4;
   localparam int DLY_W = 29;
   localparam int ATTEN_W = 6;
   localparam logic [DLY_W-1:0] CNT_ONE = 29'h0000001;
   localparam logic [ATTEN_W-1:0] ATTEN_START = 6'h3F;
   localparam logic [3:0] LEVEL_MAX_DB = 4'h9;
   // timing
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned PWRUP_MAX_S = 4;
   localparam int unsigned PWRUP_MAX_CYC = PWRUP_MAX_S * CLK_MHZ * 1000000;
   localparam int unsigned RAMP_STEP_US = 10;
   localparam int unsigned RAMP_STEP_CYC = RAMP_STEP_US * CLK_MHZ;
   // field encodings
   typedef enum logic [2:0] {
      CFG_DIFF, CFG_SE4, CFG_PSEUDO, CFG_BTL, CFG_HP_BTL
   } cfg_mode_t;
   typedef enum logic [1:0] {IDLE_HIZ, IDLE_VCM, IDLE_HALF} idle_t;
   typedef enum logic [1:0] {HS_NONE, HS_STEREO, HS_MONO, HS_MIC} hs_type_t;
endpackage : drv_pwr_pkg

// [load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module load_model (
   input wire logic clk,
   input wire logic [3:0] short_cmd,
   input wire logic [1:0] plug_cmd,
   output logic [3:0] short_det,
   output logic jack_in,
   output logic mic_in,
   output logic mono_in
);
   // loads and jack start quiet so reset sees no short
   // plug codes: 0 empty, 1 stereo, 2 mono, 3 headset with mic
   // one process only, so each pin has a single driver
   initial begin
      short_det = 4'h0;
      jack_in = 1'b0;
      mic_in = 1'b0;
      mono_in = 1'b0;
      forever begin
         @(posedge clk);
         #1;
         short_det <= short_cmd;
         jack_in <= (plug_cmd != 2'h0);
         mono_in <= (plug_cmd == 2'h2);
         mic_in <= (plug_cmd == 2'h3);
      end
   end
endmodule : load_model
`default_nettype wire

// [output_driver_power_control.sv]
`timescale 1ns/1ps
`default_nettype none
module output_driver_power_control
   import drv_pwr_pkg::*;
#(
   parameter logic [DLY_W-1:0] PWRUP_MAX = DLY_W'(PWRUP_MAX_CYC),
   parameter logic [DLY_W-1:0] RAMP_STEP = DLY_W'(RAMP_STEP_CYC)
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [6:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic [4*DRV_N-1:0] LEVEL_DB,
   input wire logic [DRV_N-1:0] SHORT_DET,
   input wire logic JACK_IN,
   input wire logic MIC_IN,
   input wire logic MONO_IN,
   output logic [DRV_N-1:0] DRV_POWER,
   output logic [DRV_N-1:0] DRV_HOLD_VCM,
   output logic [DRV_N-1:0] DRV_HOLD_HALF,
   output logic [DRV_N-1:0] DRV_VCM_FIXED,
   output logic [DRV_N-1:0] DRV_ILIMIT,
   output logic [4*DRV_N-1:0] DRV_GAIN,
   output logic [ATTEN_W*DRV_N-1:0] DRV_ATTEN,
   output logic [2:0] DRV_MODE,
   output logic DIRECT_L,
   output logic DIRECT_R
);
   // power-up delay: zero is immediate, each step doubles up to max
   function automatic logic [DLY_W-1:0] dly_cyc(
      input logic [3:0] code,
      input logic [DLY_W-1:0] max
   );
      dly_cyc = (code == 4'h0) ? '0 : (max >> (4'hF - code));
   endfunction : dly_cyc

   // level setting saturates instead of wrapping
   function automatic logic [3:0] clamp_db(input logic [3:0] v);
      clamp_db = (v > LEVEL_MAX_DB) ? LEVEL_MAX_DB : v;
   endfunction : clamp_db

   logic [7:0] hsdet_q;
   logic [7:0] outcfg_q;
   logic [7:0] ramp_q;
   logic [7:0] pudly_q;
   logic [7:0] rdata_d;
   logic [DRV_N+2:0] sync_a_q;
   logic [DRV_N+2:0] sync_b_q;
   logic [1:0] hs_type_q;
   logic [1:0] hs_type_d;
   logic [DRV_N-1:0] short_s;
   logic jack_s;
   logic mic_s;
   logic mono_s;
   logic wr_hsdet;
   logic wr_outcfg;
   logic wr_ramp;
   logic wr_pudly;
   cfg_mode_t mode;
   idle_t idle;
   logic [DRV_N-1:0] req_raw;
   logic [DRV_N-1:0] req_w;
   logic [DRV_N-1:0] spare_w;
   logic [DLY_W-1:0] delay_w;
   logic [DRV_N-1:0] powered_w;
   logic [DRV_N-1:0] flag_w;
   logic [DRV_N-1:0] limit_w;
   logic [ATTEN_W*DRV_N-1:0] atten_w;
   logic [4*DRV_N-1:0] gain_w;
   logic [DRV_N-1:0] hold_vcm_w;
   logic [DRV_N-1:0] hold_half_w;

   // pin synchronisers; only the second stage is read
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         sync_a_q <= '0;
         sync_b_q <= '0;
      end else begin
         sync_a_q <= {MONO_IN, MIC_IN, JACK_IN, SHORT_DET};
         sync_b_q <= sync_a_q;
      end
   end

   // synchronised pin views
   assign short_s = sync_b_q[DRV_N-1:0];
   assign jack_s = sync_b_q[DRV_N];
   assign mic_s = sync_b_q[DRV_N+1];
   assign mono_s = sync_b_q[DRV_N+2];

   // write decode
   assign wr_hsdet = REG_WR && (REG_ADDR == ADDR_HSDET);
   assign wr_outcfg = REG_WR && (REG_ADDR == ADDR_OUTCFG);
   assign wr_ramp = REG_WR && (REG_ADDR == ADDR_RAMP);
   assign wr_pudly = REG_WR && (REG_ADDR == ADDR_PUDLY);

   // writable registers; detected type bits are not stored here
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         hsdet_q <= RST_HSDET;
         outcfg_q <= RST_OUTCFG;
         ramp_q <= RST_RAMP;
         pudly_q <= RST_PUDLY;
      end else begin
         if (wr_hsdet) begin
            hsdet_q <= REG_WDATA;
         end
         if (wr_outcfg) begin
            outcfg_q <= REG_WDATA;
         end
         if (wr_ramp) begin
            ramp_q <= REG_WDATA;
         end
         if (wr_pudly) begin
            pudly_q <= REG_WDATA;
         end
      end
   end

   // field views
   assign mode = cfg_mode_t'(outcfg_q[OUTCFG_MODE_LSB +: 3]);
   assign idle = idle_t'(pudly_q[PUDLY_IDLE_LSB +: 2]);
   assign req_raw = outcfg_q[OUTCFG_PWR_LSB +: DRV_N];
   assign delay_w = dly_cyc(pudly_q[PUDLY_CODE_LSB +: 4], PWRUP_MAX);

   assign req_w[0] = req_raw[0];
   assign req_w[1] = (mode == CFG_DIFF || mode == CFG_BTL) ?
      req_raw[0] : req_raw[1];
   assign req_w[2] = req_raw[2];
   assign req_w[3] = (mode == CFG_SE4 || mode == CFG_PSEUDO) ?
      req_raw[3] : req_raw[2];

   assign spare_w = (mode == CFG_PSEUDO) ? 4'hC : 4'h0;

   // per-driver sequencers
   drv_if dif[DRV_N] ();
   genvar i;
   generate
      for (i = 0; i < DRV_N; i = i + 1) begin : g_drv
         assign dif[i].pwr_req = req_w[i];
         assign dif[i].auto_off = ramp_q[RAMP_AUTO_OFF_BIT];
         assign dif[i].ramp_en = ramp_q[RAMP_EN_BIT] & ~spare_w[i];
         assign dif[i].shorted = short_s[i];
         assign dif[i].delay_cyc = delay_w;
         assign powered_w[i] = dif[i].powered;
         assign flag_w[i] = dif[i].short_flag;
         assign limit_w[i] = dif[i].limiting;
         assign atten_w[ATTEN_W*i +: ATTEN_W] = dif[i].atten;
         assign gain_w[4*i +: 4] = clamp_db(LEVEL_DB[4*i +: 4]);
         driver_seq #(
            .RAMP_STEP(RAMP_STEP)
         ) u_seq (
            .clk(CLK_SYS),
            .rst_b(RST_B),
            .d(dif[i])
         );
      end
   endgenerate

   assign hold_vcm_w = (idle == IDLE_VCM) ? ~powered_w : '0;
   assign hold_half_w = (idle == IDLE_HALF) ? ~powered_w : '0;

   always_comb begin
      hs_type_d = HS_NONE;
      if (hsdet_q[HSDET_EN_BIT] && jack_s) begin
         if (mic_s) begin
            hs_type_d = HS_MIC;
         end else if (mono_s && !hsdet_q[HSDET_AC_BIT]) begin
            hs_type_d = HS_MONO;
         end else begin
            hs_type_d = HS_STEREO;
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      case (REG_ADDR)
         ADDR_HSDET: begin
            rdata_d = {hsdet_q[HSDET_EN_BIT], hs_type_q,
               hsdet_q[HSDET_AC_BIT:0]};
         end
         ADDR_OUTCFG: rdata_d = outcfg_q;
         ADDR_RAMP: rdata_d = ramp_q;
         ADDR_PUDLY: rdata_d = pudly_q;
         ADDR_SHORT: rdata_d = {powered_w, flag_w};
         default: rdata_d = 8'h00;
      endcase
   end

   // read data and detected type
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 8'h00;
         hs_type_q <= HS_NONE;
      end else begin
         if (REG_RD) begin
            REG_RDATA <= rdata_d;
         end
         hs_type_q <= hs_type_d;
      end
   end

   // driver-side outputs, one flop each so pins never glitch
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         DRV_POWER <= '0;
         DRV_HOLD_VCM <= '0;
         DRV_HOLD_HALF <= '0;
         DRV_VCM_FIXED <= '0;
         DRV_ILIMIT <= '0;
         DRV_GAIN <= '0;
         DRV_ATTEN <= '1;
         DRV_MODE <= 3'h0;
      end else begin
         DRV_POWER <= powered_w;
         DRV_HOLD_VCM <= hold_vcm_w;
         DRV_HOLD_HALF <= hold_half_w;
         DRV_VCM_FIXED <= spare_w & powered_w;
         DRV_ILIMIT <= limit_w;
         DRV_GAIN <= gain_w;
         DRV_ATTEN <= atten_w;
         DRV_MODE <= mode;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         DIRECT_L <= 1'b0;
         DIRECT_R <= 1'b0;
      end else begin
         DIRECT_L <= outcfg_q[OUTCFG_DIRECT_BIT];
         DIRECT_R <= outcfg_q[OUTCFG_DIRECT_BIT];
      end
   end

   property p_gain_cap;
      @(posedge CLK_SYS) disable iff (!RST_B)
      LEVEL_DB[3:0] > LEVEL_MAX_DB |=> DRV_GAIN[3:0] == LEVEL_MAX_DB;
   endproperty
   a_gain_cap: assert property (p_gain_cap) else $error("gain over 9");

   property p_idle_hiz;
      @(posedge CLK_SYS) disable iff (!RST_B)
      (idle == IDLE_HIZ) ##1 (idle == IDLE_HIZ)
         |-> DRV_HOLD_VCM == '0 && DRV_HOLD_HALF == '0;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("hold in hiz");

   property p_ac_mono;
      @(posedge CLK_SYS) disable iff (!RST_B)
      hsdet_q[HSDET_AC_BIT] |=> hs_type_q != HS_MONO;
   endproperty
   a_ac_mono: assert property (p_ac_mono) else $error("mono in ac");

   property p_dly_zero;
      @(posedge CLK_SYS) disable iff (!RST_B)
      pudly_q[PUDLY_CODE_LSB +: 4] == 4'h0 |-> delay_w == '0;
   endproperty
   a_dly_zero: assert property (p_dly_zero) else $error("no zero");

   property p_dly_max;
      @(posedge CLK_SYS) disable iff (!RST_B)
      pudly_q[PUDLY_CODE_LSB +: 4] == 4'hF |-> delay_w == PWRUP_MAX;
   endproperty
   a_dly_max: assert property (p_dly_max) else $error("max delay off");

   property p_direct;
      @(posedge CLK_SYS) disable iff (!RST_B)
      outcfg_q[OUTCFG_DIRECT_BIT] |=> DIRECT_L && DIRECT_R;
   endproperty
   a_direct: assert property (p_direct) else $error("direct path off");
endmodule : output_driver_power_control
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      mismatches++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
   end \
end
module tb_top;
   import drv_pwr_pkg::*;
   logic clk_sys, rst_b, reg_wr, reg_rd, jack_in, mic_in, mono_in;
   logic dir_l, dir_r;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [15:0] level_db, gain;
   logic [3:0] short_det, short_cmd, pwr, vcm, half, vfix, ilim;
   logic [1:0] plug_cmd;
   logic [23:0] atten;
   logic [2:0] mode;
   logic [3:0] code;
   int mismatches, samples_checked, cycles, n, dly;

   output_driver_power_control #(.PWRUP_MAX(29'h0000040),
      .RAMP_STEP(29'h0000002)) i_output_driver_power_control (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .LEVEL_DB(level_db), .SHORT_DET(short_det),
      .JACK_IN(jack_in), .MIC_IN(mic_in), .MONO_IN(mono_in),
      .DRV_POWER(pwr), .DRV_HOLD_VCM(vcm), .DRV_HOLD_HALF(half),
      .DRV_VCM_FIXED(vfix), .DRV_ILIMIT(ilim), .DRV_GAIN(gain),
      .DRV_ATTEN(atten), .DRV_MODE(mode), .DIRECT_L(dir_l),
      .DIRECT_R(dir_r));

   load_model i_load_model (.clk(clk_sys), .short_cmd(short_cmd),
      .plug_cmd(plug_cmd), .short_det(short_det), .jack_in(jack_in),
      .mic_in(mic_in), .mono_in(mono_in));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // hang guard, whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [7:0] ex);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_rd = 1'b0;
      `CHK("register", ex, reg_rdata)
   endtask : rd

   task automatic wait_cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   // request driver 0 alone, count edges until it is powered
   task automatic pwr_up();
      wr(ADDR_OUTCFG, 8'h11);
      n = 0;
      while (pwr[0] !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : pwr_up

   task automatic pwr_off();
      wr(ADDR_OUTCFG, 8'h01);
      wait_cyc(4);
      `CHK("power off", 1'b0, pwr[0])
   endtask : pwr_off

   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      level_db = 16'h39AF;
      short_cmd = 4'h0;
      plug_cmd = 2'h0;
      repeat (10) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;

      // reset values, refused writes, level clamp
      rd(ADDR_HSDET, RST_HSDET);
      rd(ADDR_OUTCFG, RST_OUTCFG);
      rd(ADDR_RAMP, RST_RAMP);
      rd(ADDR_PUDLY, RST_PUDLY);
      rd(ADDR_SHORT, 8'h00);
      wr(ADDR_SHORT, 8'hFF);
      rd(ADDR_SHORT, 8'h00);
      wr(7'h10, 8'hAA);
      rd(7'h10, 8'h00);
      `CHK("gain", 16'h3999, gain)
      $display("test registers done");

      // every configuration code and the direct path
      for (int m = 0; m < 5; m++) begin
         wr(ADDR_OUTCFG, 8'(m));
         wait_cyc(2);
         `CHK("mode", 3'(m), mode)
         rd(ADDR_OUTCFG, 8'(m));
      end
      wr(ADDR_OUTCFG, 8'h08);
      wait_cyc(2);
      `CHK("direct", 2'b11, {dir_l, dir_r})
      wr(ADDR_OUTCFG, 8'hF2);
      wait_cyc(8);
      `CHK("vcm spare", 4'hC, vfix)
      wr(ADDR_OUTCFG, 8'h13);
      wait_cyc(8);
      `CHK("btl pair", 4'h3, pwr)
      wr(ADDR_OUTCFG, 8'h44);
      wait_cyc(8);
      `CHK("hp btl pair", 4'hC, pwr)
      wr(ADDR_OUTCFG, 8'h01);
      wait_cyc(4);
      $display("test modes done");

      // powered-down output conditions
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_PUDLY, 8'(i << 2));
         wait_cyc(2);
         v = (i == 1) ? 8'hF0 : (i == 2) ? 8'h0F : 8'h00;
         `CHK("idle hold", v, {vcm, half})
         `CHK("idle power", 4'h0, pwr)
      end
      $display("test idle done");

      // delay codes: config written first, then power requested
      for (int i = 0; i < 3; i++) begin
         code = (i == 0) ? 4'hF : (i == 1) ? 4'hC : 4'h0;
         dly = (code == 4'h0) ? 0 : (64 >> (15 - code));
         wr(ADDR_PUDLY, {code, 4'h0});
         wr(ADDR_OUTCFG, 8'h01);
         pwr_up();
         `CHK("powerup cycles", 3 + dly, n)
         `CHK("start atten", ATTEN_START, atten[5:0])
         rd(ADDR_SHORT, 8'h10);
         pwr_off();
      end
      // soft ramp walks attenuation down to zero
      pwr_up();
      n = 0;
      while (atten[5:0] !== 6'h00 && n < 300) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      `CHK("ramp length ok", 1'b1, (n >= 120 && n <= 132))
      pwr_off();
      wr(ADDR_RAMP, 8'h00);
      pwr_up();
      wait_cyc(4);
      `CHK("no ramp atten", 6'h00, atten[5:0])
      $display("test powerup done");

      // short held with limiting only
      short_cmd = 4'h1;
      wait_cyc(6);
      `CHK("limit", 4'h1, ilim)
      `CHK("stays on", 1'b1, pwr[0])
      rd(ADDR_SHORT, 8'h11);
      short_cmd = 4'h0;
      wait_cyc(6);
      rd(ADDR_SHORT, 8'h10);
      // automatic shutdown and sticky flag
      wr(ADDR_RAMP, 8'h03);
      short_cmd = 4'h1;
      wait_cyc(6);
      `CHK("auto off", 1'b0, pwr[0])
      short_cmd = 4'h0;
      wait_cyc(6);
      rd(ADDR_SHORT, 8'h01);
      wr(ADDR_OUTCFG, 8'h11);
      wait_cyc(6);
      `CHK("still off", 1'b0, pwr[0])
      pwr_off();
      pwr_up();
      `CHK("repowered", 1'b1, pwr[0])
      rd(ADDR_SHORT, 8'h10);
      pwr_off();
      $display("test short done");

      // headset type, read-only field, ac-coupled merge
      // analog bias left to host
      wr(ADDR_HSDET, 8'hE0);
      rd(ADDR_HSDET, 8'h80);
      for (int p = 0; p < 4; p++) begin
         plug_cmd = 2'(p);
         wait_cyc(6);
         rd(ADDR_HSDET, {1'b1, 2'(p), 5'h00});
      end
      plug_cmd = 2'h2;
      wr(ADDR_HSDET, 8'h90);
      wait_cyc(6);
      rd(ADDR_HSDET, 8'hB0);
      $display("test headset done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
